// File: frtc_consts.vh
/*
 * shared constants of the free-running timer with capture:
 * register byte addresses, field positions, reset values, clock choices.
 * assumes inclusion by the capture and top design files of the timer, once per file.
 */
`ifndef FRTC_CONSTS_VH
`define FRTC_CONSTS_VH

// ------------------------------------------------------------
// register byte addresses, one aligned word each
// ------------------------------------------------------------
`define FRTC_OFF_CTRL1    8'h00
`define FRTC_OFF_CTRL2    8'h04
`define FRTC_OFF_FLAGS    8'h08
`define FRTC_OFF_CNT_HI   8'h0c
`define FRTC_OFF_CNT_LO   8'h10
`define FRTC_OFF_ACNT_HI  8'h14
`define FRTC_OFF_ACNT_LO  8'h18
`define FRTC_OFF_CAP1_HI  8'h1c
`define FRTC_OFF_CAP1_LO  8'h20
`define FRTC_OFF_CAP2_HI  8'h24
`define FRTC_OFF_CAP2_LO  8'h28

// ------------------------------------------------------------
// control register one fields
// ------------------------------------------------------------
`define FRTC_C1_CAP_IE    7
`define FRTC_C1_CAP1_EDGE 6
`define FRTC_C1_OVF_IE    5
`define FRTC_C1_MASK      8'he0

// ------------------------------------------------------------
// control register two fields
// ------------------------------------------------------------
`define FRTC_C2_PWM       5
`define FRTC_C2_OPM       4
`define FRTC_C2_CAP2_EDGE 3
`define FRTC_C2_EXT_EDGE  2
`define FRTC_C2_CLK_HI    1
`define FRTC_C2_CLK_LO    0
`define FRTC_C2_MASK      8'h3f

// ------------------------------------------------------------
// flags register fields
// ------------------------------------------------------------
`define FRTC_F_OVF        0
`define FRTC_F_CAP1       1
`define FRTC_F_CAP2       2

// ------------------------------------------------------------
// timer clock select encodings and reset values
// ------------------------------------------------------------
`define FRTC_CLK_DIV4     2'b00
`define FRTC_CLK_DIV2     2'b01
`define FRTC_CLK_DIV8     2'b10
`define FRTC_CLK_EXT      2'b11
`define FRTC_CNT_RESET    16'hfffc
`define FRTC_CNT_TOP      16'hffff
`define FRTC_CTRL_RESET   8'h00

`endif

// File: frtc_sync.v
/*
 * two flip-flop synchroniser for one pin level.
 * assumes the input is asynchronous to i_clk; only o_q may be read.
 */
`timescale 1ns/1ns
module frtc_sync (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_d,
    output wire o_q
);
    reg meta_q;
    reg sync_q;

    // two stages, first stage read only by second
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end

    assign o_q = sync_q;
endmodule

// File: frtc_capture.v
/*
 * one input capture channel: edge detect, capture value, flag with
 * two-step clear, and inhibit after a high-byte read.
 * assumes i_pin already synchronised to i_clk.
 */
`timescale 1ns/1ns
`include "frtc_consts.vh"
module frtc_capture (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_pin,
    input wire i_edge_sel,
    input wire i_usable,
    input wire [15:0] i_count,
    input wire i_hi_read,
    input wire i_lo_read,
    input wire i_lo_access,
    input wire i_status_seen,
    output wire o_flag,
    output wire [15:0] o_value
);
    reg pin_prev_q;
    reg flag_q;
    reg arm_q;
    reg inhibit_q;
    reg [15:0] value_q;
    wire edge_hit;
    wire cap_evt;
    wire flag_clr;

    assign edge_hit = i_edge_sel ? (i_pin & ~pin_prev_q)
                                 : (~i_pin & pin_prev_q);
    assign cap_evt = edge_hit & i_usable & ~inhibit_q;
    assign flag_clr = arm_q & i_lo_access;

    // edge history, capture value, flag, arm and inhibit
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            pin_prev_q <= 1'b0;
            flag_q <= 1'b0;
            arm_q <= 1'b0;
            inhibit_q <= 1'b0;
            value_q <= 16'h0000;
        end else begin
            pin_prev_q <= i_pin;
            if (cap_evt) begin
                value_q <= i_count;
            end
            flag_q <= cap_evt | (flag_q & ~flag_clr); // set wins
            if (flag_clr) begin
                arm_q <= 1'b0;
            end else if (i_status_seen) begin
                arm_q <= 1'b1;
            end
            if (i_hi_read) begin
                inhibit_q <= 1'b1;
            end else if (i_lo_read) begin
                inhibit_q <= 1'b0;
            end
        end
    end

    assign o_flag = flag_q;
    assign o_value = value_q;
endmodule

// File: frtc_top.v
/*
 * free-running 16-bit timer with prescaler or external clock,
 * overflow flag and two input capture channels, behind an apb slave.
 * assumes a single clock, cpu interrupt mask and halt from same domain,
 * and the external clock and capture pins asynchronous.
 */
// Decided for this implementation: the register offsets and the APB slave port.
// Function
// - 16-bit free-running up-counter from prescaler or external clock.
// - counter loads fffc on reset and on any low count byte write.
// - internal clock repeats every 131072, 262144 or 524288 cycles.
// - two views of counter; alternate low read keeps overflow flag.
// - high read buffers low byte, frozen until low byte read.
// - after a completed sequence, lone low read returns live low byte.
// - overflow flag sets when counter wraps ffff to 0000.
// - overflow irq when flag, enable and mask clear; else pending.
// - overflow clears after status read then primary low access.
// - counter keeps running unchanged in wait state.
// - halt freezes counter; interrupt wake resumes, reset restarts.
// - both clock select bits set picks the external clock.
// - an edge select bit picks the active external clock edge.
// - external clock advances are synchronised to the cpu clock.
// - capture edge latches count into channel register, sets flag.
// - each channel has its own capture edge select bit.
// - one capture irq enable covers both channels, pending otherwise.
// - capture flag clears after status read then low capture access.
// - high capture read blocks captures and flag until low read.
// - in one-pulse or pwm mode only channel two captures.
// - capture pins always feed the timer, output driven too.
`timescale 1ns/1ns
`include "frtc_consts.vh"
module frtc_top (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire i_ext_clock_pin,
    input wire i_capture1_pin,
    input wire i_capture2_pin,
    input wire i_irq_mask,
    input wire i_halt,
    output wire o_overflow_irq,
    output wire o_capture_irq
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg [7:0] ctrl1_q;
    reg [7:0] ctrl2_q;
    reg [15:0] count_q;
    reg [2:0] presc_q;
    reg ext_prev_q;
    reg overflow_flag_q;
    reg ovf_arm_q;
    reg [7:0] lo_buf_q;
    reg lo_lock_q;
    reg addr_ok;
    reg [31:0] rd_mux;
    reg int_tick;
    wire ext_sync;
    wire cap1_sync;
    wire cap2_sync;
    wire bus_setup;
    wire bus_access;
    wire wr_ok;
    wire rd_ok;
    wire acc_ok;
    wire hit_cnt_hi;
    wire hit_cnt_lo;
    wire hit_acnt_hi;
    wire hit_acnt_lo;
    wire hit_cap1_hi;
    wire hit_cap1_lo;
    wire hit_cap2_hi;
    wire hit_cap2_lo;
    wire hit_flags;
    wire [1:0] timer_clock_select;
    wire ext_clock_edge_select;
    wire overflow_irq_enable;
    wire capture_irq_enable;
    wire one_pulse_mode;
    wire pwm_mode;
    wire ext_edge;
    wire tick;
    wire count_reload;
    wire ovf_set;
    wire ovf_clr;
    wire cap1_flag;
    wire cap2_flag;
    wire [15:0] cap1_value;
    wire [15:0] cap2_value;
    wire cap1_usable;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // phases and address hits
    assign bus_setup = i_psel & ~i_penable;
    assign bus_access = i_psel & i_penable;
    assign hit_flags = (i_paddr == `FRTC_OFF_FLAGS);
    assign hit_cnt_hi = (i_paddr == `FRTC_OFF_CNT_HI);
    assign hit_cnt_lo = (i_paddr == `FRTC_OFF_CNT_LO);
    assign hit_acnt_hi = (i_paddr == `FRTC_OFF_ACNT_HI);
    assign hit_acnt_lo = (i_paddr == `FRTC_OFF_ACNT_LO);
    assign hit_cap1_hi = (i_paddr == `FRTC_OFF_CAP1_HI);
    assign hit_cap1_lo = (i_paddr == `FRTC_OFF_CAP1_LO);
    assign hit_cap2_hi = (i_paddr == `FRTC_OFF_CAP2_HI);
    assign hit_cap2_lo = (i_paddr == `FRTC_OFF_CAP2_LO);

    // mapped address check
    always @* begin
        case (i_paddr)
            `FRTC_OFF_CTRL1,
            `FRTC_OFF_CTRL2,
            `FRTC_OFF_FLAGS,
            `FRTC_OFF_CNT_HI,
            `FRTC_OFF_CNT_LO,
            `FRTC_OFF_ACNT_HI,
            `FRTC_OFF_ACNT_LO,
            `FRTC_OFF_CAP1_HI,
            `FRTC_OFF_CAP1_LO,
            `FRTC_OFF_CAP2_HI,
            `FRTC_OFF_CAP2_LO: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // zero wait states; unmapped access answers with an error
    assign o_pready = 1'b1;
    assign o_pslverr = bus_access & ~addr_ok;
    assign acc_ok = bus_access & addr_ok;
    assign wr_ok = acc_ok & i_pwrite;
    assign rd_ok = acc_ok & ~i_pwrite;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // control writes take effect at the access edge
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl1_q <= `FRTC_CTRL_RESET;
            ctrl2_q <= `FRTC_CTRL_RESET;
        end else if (wr_ok) begin
            if (i_paddr == `FRTC_OFF_CTRL1) begin
                ctrl1_q <= i_pwdata[7:0] & `FRTC_C1_MASK;
            end
            if (i_paddr == `FRTC_OFF_CTRL2) begin
                ctrl2_q <= i_pwdata[7:0] & `FRTC_C2_MASK;
            end
        end
    end

    // named control fields
    assign timer_clock_select = ctrl2_q[`FRTC_C2_CLK_HI:`FRTC_C2_CLK_LO];
    assign ext_clock_edge_select = ctrl2_q[`FRTC_C2_EXT_EDGE];
    assign one_pulse_mode = ctrl2_q[`FRTC_C2_OPM];
    assign pwm_mode = ctrl2_q[`FRTC_C2_PWM];
    assign overflow_irq_enable = ctrl1_q[`FRTC_C1_OVF_IE];
    assign capture_irq_enable = ctrl1_q[`FRTC_C1_CAP_IE];

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // external clock into cpu domain
    frtc_sync u_sync_ext (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_d(i_ext_clock_pin),
        .o_q(ext_sync)
    );

    frtc_sync u_sync_cap1 (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_d(i_capture1_pin),
        .o_q(cap1_sync)
    );

    frtc_sync u_sync_cap2 (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_d(i_capture2_pin),
        .o_q(cap2_sync)
    );

    // ------------------------------------------------------------
    // timer clock
    // ------------------------------------------------------------
    // divide by 2, 4 or 8
    always @* begin
        case (timer_clock_select)
            `FRTC_CLK_DIV2: int_tick = presc_q[0];
            `FRTC_CLK_DIV4: int_tick = &presc_q[1:0];
            `FRTC_CLK_DIV8: int_tick = &presc_q;
            default: int_tick = 1'b0;
        endcase
    end

    assign ext_edge = ext_clock_edge_select ? (ext_sync & ~ext_prev_q)
                                            : (~ext_sync & ext_prev_q);

    assign tick = ~i_halt & ((timer_clock_select == `FRTC_CLK_EXT) ?
                             ext_edge : int_tick);

    // prescaler frozen in halt, external edge history always updated
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            presc_q <= 3'h0;
            ext_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_sync;
            if (!i_halt) begin
                presc_q <= presc_q + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // counter and overflow
    // ------------------------------------------------------------
    // low count byte writes reload
    assign count_reload = wr_ok & (hit_cnt_lo | hit_acnt_lo);

    // wait state has no effect here
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            count_q <= `FRTC_CNT_RESET;
        end else if (count_reload) begin
            count_q <= `FRTC_CNT_RESET;
        end else if (tick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    assign ovf_set = tick & ~count_reload & (count_q == `FRTC_CNT_TOP);
    assign ovf_clr = ovf_arm_q & acc_ok & hit_cnt_lo;

    // overflow flag with set over clear, arm from status read
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            overflow_flag_q <= 1'b0;
            ovf_arm_q <= 1'b0;
        end else begin
            overflow_flag_q <= ovf_set | (overflow_flag_q & ~ovf_clr);
            if (ovf_clr) begin
                ovf_arm_q <= 1'b0;
            end else if (rd_ok & hit_flags & o_prdata[`FRTC_F_OVF]) begin
                ovf_arm_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // buffered 16-bit count read
    // ------------------------------------------------------------
    // high read setup freezes low byte with it
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            lo_buf_q <= 8'h00;
            lo_lock_q <= 1'b0;
        end else if (bus_setup & ~i_pwrite & ~lo_lock_q &
                     (hit_cnt_hi | hit_acnt_hi)) begin
            lo_buf_q <= count_q[7:0];
            lo_lock_q <= 1'b1;
        end else if (rd_ok & (hit_cnt_lo | hit_acnt_lo)) begin
            lo_lock_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // capture channels
    // ------------------------------------------------------------
    // channel one off in pulse modes
    assign cap1_usable = ~(one_pulse_mode | pwm_mode);

    frtc_capture u_cap1 (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_pin(cap1_sync),
        .i_edge_sel(ctrl1_q[`FRTC_C1_CAP1_EDGE]),
        .i_usable(cap1_usable),
        .i_count(count_q),
        .i_hi_read(rd_ok & hit_cap1_hi),
        .i_lo_read(rd_ok & hit_cap1_lo),
        .i_lo_access(acc_ok & hit_cap1_lo),
        .i_status_seen(rd_ok & hit_flags & o_prdata[`FRTC_F_CAP1]),
        .o_flag(cap1_flag),
        .o_value(cap1_value)
    );

    frtc_capture u_cap2 (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_pin(cap2_sync),
        .i_edge_sel(ctrl2_q[`FRTC_C2_CAP2_EDGE]),
        .i_usable(1'b1),
        .i_count(count_q),
        .i_hi_read(rd_ok & hit_cap2_hi),
        .i_lo_read(rd_ok & hit_cap2_lo),
        .i_lo_access(acc_ok & hit_cap2_lo),
        .i_status_seen(rd_ok & hit_flags & o_prdata[`FRTC_F_CAP2]),
        .o_flag(cap2_flag),
        .o_value(cap2_value)
    );

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    // overflow request, pending while masked
    assign o_overflow_irq = overflow_flag_q & overflow_irq_enable &
                            ~i_irq_mask;
    assign o_capture_irq = (cap1_flag | cap2_flag) & capture_irq_enable &
                           ~i_irq_mask;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    // read mux, unmapped reads zero
    always @* begin
        rd_mux = 32'h00000000;
        case (i_paddr)
            `FRTC_OFF_CTRL1: rd_mux[7:0] = ctrl1_q;
            `FRTC_OFF_CTRL2: rd_mux[7:0] = ctrl2_q;
            `FRTC_OFF_FLAGS: begin
                rd_mux[`FRTC_F_OVF] = overflow_flag_q;
                rd_mux[`FRTC_F_CAP1] = cap1_flag;
                rd_mux[`FRTC_F_CAP2] = cap2_flag;
            end
            `FRTC_OFF_CNT_HI: rd_mux[7:0] = count_q[15:8];
            `FRTC_OFF_ACNT_HI: rd_mux[7:0] = count_q[15:8];
            `FRTC_OFF_CNT_LO: rd_mux[7:0] = lo_lock_q ? lo_buf_q :
                                            count_q[7:0];
            `FRTC_OFF_ACNT_LO: rd_mux[7:0] = lo_lock_q ? lo_buf_q :
                                             count_q[7:0];
            `FRTC_OFF_CAP1_HI: rd_mux[7:0] = cap1_value[15:8];
            `FRTC_OFF_CAP1_LO: rd_mux[7:0] = cap1_value[7:0];
            `FRTC_OFF_CAP2_HI: rd_mux[7:0] = cap2_value[15:8];
            `FRTC_OFF_CAP2_LO: rd_mux[7:0] = cap2_value[7:0];
            default: rd_mux = 32'h00000000;
        endcase
    end

    // read data registered in the setup cycle, held through access
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h00000000;
        end else if (bus_setup & ~i_pwrite) begin
            o_prdata <= rd_mux;
        end
    end
endmodule

// File: frtc_dummy_never.v
/*
 * holds no logic; the timer lives in its three other design files.
 */

// File: frtc_monitor.sv
/*
 * port checker for the free-running timer with capture.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ns
module frtc_monitor (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire o_pready,
    input wire o_pslverr,
    input wire i_ext_clock_pin,
    input wire i_capture1_pin,
    input wire i_capture2_pin,
    input wire i_irq_mask,
    input wire i_halt,
    input wire o_overflow_irq,
    input wire o_capture_irq
);
// ----------------------------------------
// bus decode and properties
// ----------------------------------------
// access phase and mapped word addresses
wire acc = i_psel && i_penable;
wire mapped = (i_paddr[1:0] == 2'b00) && (i_paddr <= 8'h28);
wire ovf_keep = acc && (i_paddr == 8'h10 || i_paddr == 8'h00);
wire cap_keep = acc && (i_paddr == 8'h00 || i_paddr == 8'h04 ||
    i_paddr == 8'h20 || i_paddr == 8'h28);
default clocking @(posedge i_clk); endclocking
default disable iff (!i_rst_n);
// status read while the overflow request is up
sequence s_flag_rd;
    i_psel && !i_penable && !i_pwrite && i_paddr == 8'h08 &&
        o_overflow_irq ##1 acc;
endsequence
// write to the primary low count byte
sequence s_lo_wr;
    i_psel && !i_penable && i_pwrite && i_paddr == 8'h10 ##1 acc;
endsequence
a_ovf_clear: assert property (
    s_flag_rd ##1 s_lo_wr |=> !o_overflow_irq)
    else $error("overflow flag kept after clear");
a_ovf_hold: assert property (
    o_overflow_irq && !ovf_keep |=> o_overflow_irq || i_irq_mask)
    else $error("overflow request dropped");
a_ovf_masked: assert property (
    o_overflow_irq |-> !i_irq_mask)
    else $error("overflow request while masked");
a_cap_masked: assert property (
    o_capture_irq |-> !i_irq_mask)
    else $error("capture request while masked");
a_cap_hold: assert property (
    o_capture_irq && !cap_keep |=> o_capture_irq || i_irq_mask)
    else $error("capture request dropped");
a_reset_quiet: assert property (
    $rose(i_rst_n) |-> !o_overflow_irq && !o_capture_irq &&
        o_prdata == 32'h0)
    else $error("outputs not cleared by reset");
a_prdata_stands: assert property (
    !(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata))
    else $error("read data changed outside read setup");
a_slave_ready: assert property (o_pready)
    else $error("ready low");
a_err_unmapped: assert property (o_pslverr == (acc && !mapped))
    else $error("slave error decode wrong");
endmodule

// File: frtc_pins.sv
/*
 * model of the external clock and capture pins.
 * assumes tasks are called just after a rising clock edge.
 */
`timescale 1ns/1ns
module frtc_pins (
    input wire i_clk,
    output logic o_ext_clock_pin,
    output logic o_capture1_pin,
    output logic o_capture2_pin
);
// pins idle low
initial begin
    o_ext_clock_pin = 1'b0;
    o_capture1_pin = 1'b0;
    o_capture2_pin = 1'b0;
end
task drive(input int idx, input logic lvl);
    begin
        case (idx)
            0: o_ext_clock_pin <= lvl;
            1: o_capture1_pin <= lvl;
            default: o_capture2_pin <= lvl;
        endcase
        repeat (6) @(posedge i_clk);
    end
endtask
endmodule

// File: tb_free_running_timer_with_capture.sv
/*
 * self-checking bench of the timer with capture.
 * assumes zero-wait apb slave and pins from frtc_pins.
 */
`timescale 1ns/1ns
module tb_free_running_timer_with_capture;
typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic s;
} frtc_row_t;
logic i_clk, i_rst_n, psel, pen, pwr, mask, halt, serr;
logic [7:0] paddr, a8;
logic [31:0] pwdata, r;
wire [31:0] prdata;
wire pready, pslverr, ovf, cap, ext, c1, c2;
integer err_count, checks, cyc, i;
frtc_row_t rows [0:10] = '{
    {1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, {1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
    {1'b1, 8'h00, 32'hff, 32'h0, 1'b0}, {1'b0, 8'h00, 32'h0, 32'he0, 1'b0},
    {1'b1, 8'h04, 32'hff, 32'h0, 1'b0}, {1'b0, 8'h04, 32'h0, 32'h3f, 1'b0},
    {1'b1, 8'h04, 32'h0, 32'h0, 1'b0}, {1'b1, 8'h00, 32'h0, 32'h0, 1'b0},
    {1'b0, 8'h2c, 32'h0, 32'h0, 1'b1}, {1'b1, 8'h30, 32'h5, 32'h0, 1'b1},
    {1'b0, 8'h02, 32'h0, 32'h0, 1'b1}};
logic [1:0] sel [0:3] = '{2'b01, 2'b00, 2'b10, 2'b01};
logic hl [0:3] = '{1'b0, 1'b0, 1'b0, 1'b1};
logic [7:0] ex [0:3] = '{8'h64, 8'h32, 8'h19, 8'h00};
frtc_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_ext_clock_pin(ext), .i_capture1_pin(c1),
    .i_capture2_pin(c2), .i_irq_mask(mask), .i_halt(halt),
    .o_overflow_irq(ovf), .o_capture_irq(cap));
frtc_pins pin_u (.i_clk(i_clk), .o_ext_clock_pin(ext),
    .o_capture1_pin(c1), .o_capture2_pin(c2));
// ----------------------------------------
// clock, timeout and tasks
// ----------------------------------------
// 100 ns clock
initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
end
// hang guard
always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
        err_count = err_count + 1;
        report_and_stop;
    end
end
task report_and_stop;
    begin
        if (err_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
endtask
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
        checks = checks + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    end
endtask
// one apb transfer, select held for a following setup
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (pready !== 1'b1);
        r = prdata;
        serr = pslverr;
        pen <= 1'b0;
    end
endtask
task idle;
    begin
        psel <= 1'b0;
        @(posedge i_clk);
    end
endtask
task rdc(input logic [7:0] a, input logic [31:0] e);
    begin
        apb(1'b0, a, 32'h0);
        chk($sformatf("read %h", a), e, r);
    end
endtask
// ----------------------------------------
// main sequence
// ----------------------------------------
initial begin
    err_count = 0;
    checks = 0;
    cyc = 0;
    i_rst_n = 1'b0;
    {psel, pen, pwr, mask, halt} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    for (i = 0; i < 11; i = i + 1) begin
        apb(rows[i].w, rows[i].a, rows[i].d);
        if (!rows[i].w)
            chk("prdata", rows[i].e, r);
        chk("pslverr", {31'h0, rows[i].s}, serr);
    end
    apb(1'b1, 8'h04, 32'h03);
    apb(1'b0, 8'h08, 32'h0);
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'h20);
    rdc(8'h0c, 32'hff);
    idle;
    chk("ovf irq", 0, ovf);
    for (i = 0; i < 4; i = i + 1)
        pin_u.drive(0, i[0] ? 1'b0 : 1'b1);
    rdc(8'h0c, 32'hff);
    rdc(8'h10, 32'hfc);
    rdc(8'h10, 32'hfe);
    idle;
    pin_u.drive(0, 1'b1);
    rdc(8'h10, 32'hfe);
    idle;
    pin_u.drive(0, 1'b0);
    rdc(8'h10, 32'hff);
    idle;
    pin_u.drive(0, 1'b1);
    pin_u.drive(0, 1'b0);
    chk("ovf irq", 1, ovf);
    mask <= 1'b1;
    @(posedge i_clk);
    chk("ovf irq", 0, ovf);
    mask <= 1'b0;
    @(posedge i_clk);
    chk("ovf irq", 1, ovf);
    rdc(8'h18, 32'h0);
    rdc(8'h10, 32'h0);
    idle;
    chk("ovf irq", 1, ovf);
    rdc(8'h08, 32'h1);
    apb(1'b1, 8'h10, 32'h0);
    idle;
    chk("ovf irq", 0, ovf);
    rdc(8'h0c, 32'hff);
    rdc(8'h10, 32'hfc);
    apb(1'b1, 8'h00, 32'hc0);
    idle;
    pin_u.drive(1, 1'b1);
    chk("cap irq", 1, cap);
    rdc(8'h1c, 32'hff);
    rdc(8'h20, 32'hfc);
    idle;
    chk("cap irq", 1, cap);
    rdc(8'h08, 32'h2);
    rdc(8'h20, 32'hfc);
    idle;
    chk("cap irq", 0, cap);
    pin_u.drive(0, 1'b1);
    pin_u.drive(0, 1'b0);
    rdc(8'h1c, 32'hff);
    idle;
    pin_u.drive(1, 1'b0);
    pin_u.drive(1, 1'b1);
    chk("cap irq", 0, cap);
    rdc(8'h20, 32'hfc);
    idle;
    pin_u.drive(1, 1'b0);
    pin_u.drive(1, 1'b1);
    rdc(8'h1c, 32'hff);
    rdc(8'h20, 32'hfd);
    idle;
    pin_u.drive(2, 1'b1);
    rdc(8'h08, 32'h2);
    idle;
    pin_u.drive(2, 1'b0);
    rdc(8'h08, 32'h6);
    rdc(8'h28, 32'hfd);
    for (i = 0; i < 4; i = i + 1)
        apb(1'b0, i[0] ? (i[1] ? 8'h28 : 8'h20) : 8'h08, 32'h0);
    apb(1'b1, 8'h04, 32'h13);
    idle;
    chk("cap irq", 0, cap);
    pin_u.drive(1, 1'b0);
    pin_u.drive(1, 1'b1);
    chk("cap irq", 0, cap);
    pin_u.drive(2, 1'b1);
    pin_u.drive(2, 1'b0);
    chk("cap irq", 1, cap);
    for (i = 0; i < 4; i = i + 1) begin
        apb(1'b1, 8'h04, {30'h0, sel[i]});
        idle;
        halt <= hl[i];
        apb(1'b0, 8'h10, 32'h0);
        a8 = r[7:0];
        idle;
        repeat (197) @(posedge i_clk);
        apb(1'b0, 8'h10, 32'h0);
        a8 = r[7:0] - a8;
        chk("count step", {24'h0, ex[i]}, {24'h0, a8});
        idle;
    end
    // mid-run reset while halted restarts from the reset count
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rdc(8'h0c, 32'hff);
    rdc(8'h10, 32'hfc);
    idle;
    halt <= 1'b0;
    report_and_stop;
end
endmodule
bind frtc_top frtc_monitor mon_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_ext_clock_pin(i_ext_clock_pin), .i_capture1_pin(i_capture1_pin),
    .i_capture2_pin(i_capture2_pin), .i_irq_mask(i_irq_mask),
    .i_halt(i_halt), .o_overflow_irq(o_overflow_irq),
    .o_capture_irq(o_capture_irq));
